// ---- logic/igr_routing.sv ----
// The implementer's own choices: register access over APB and the register offsets.
`include "igr_params.svh"

module igr_routing
(
    // APB
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Processing element state
    input  wire igr_pkg::igr_el_t     pe_el,
    input  wire logic                 pe_secure,
    input  wire logic                 pe_ctx_sync,
    // Interrupt lines
    output logic                      fiq,
    output logic                      irq
);
    import igr_pkg::*;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [4:0]  cfg;
    logic [13:0] ctrl;
    logic [11:0] bpr;
    logic [15:0] prio;
    logic [10:0] pend;
    logic [31:0] req_result;
    logic [4:0]  next_cfg;
    logic [13:0] next_ctrl;
    logic [11:0] next_bpr;
    logic [15:0] next_prio;
    logic [10:0] next_pend;
    logic [31:0] next_req_result;
    logic [31:0] next_prdata;
    logic        sec_sync [2];
    logic [1:0]  el_s1;
    logic [1:0]  el_s2;
    logic        fiq_q;
    logic        irq_q;
    logic        next_fiq;
    logic        next_irq;

    logic wr_en;
    logic rd_en;
    logic addr_hit;

    assign wr_en    = psel && penable && pwrite;
    assign rd_en    = psel && penable && !pwrite;
    assign pready   = 1'b1;
    assign addr_hit = paddr == `IGR_OFF_CFG || paddr == `IGR_OFF_CTRL || paddr == `IGR_OFF_BPR
                   || paddr == `IGR_OFF_PRIO || paddr == `IGR_OFF_PEND || paddr == `IGR_OFF_STATUS
                   || paddr == `IGR_OFF_REQ;
    assign pslverr  = psel && penable && !addr_hit;

    // ----------------------------------------
    // Effective configuration
    // ----------------------------------------
    logic secdis;
    logic has_el3;
    logic el3_w32;
    logic eff_ns;
    logic eff_froute;
    logic eff_iroute;
    logic eff_g0en;
    logic eff_g1sen;
    logic eff_g1nsen;
    logic cur_secure;
    logic g1s_as_g0;

    always_comb
    begin
        secdis     = cfg[`IGR_CFG_SECDIS];
        has_el3    = cfg[`IGR_CFG_HAS_EL3];
        el3_w32    = cfg[`IGR_CFG_EL3_W32];
        eff_ns     = ctrl[`IGR_CTRL_NS];
        eff_froute = ctrl[`IGR_CTRL_FROUTE];
        eff_iroute = ctrl[`IGR_CTRL_IROUTE];
        eff_g0en   = ctrl[`IGR_CTRL_G0EN];
        eff_g1sen  = ctrl[`IGR_CTRL_G1SEN] && !secdis;
        eff_g1nsen = ctrl[`IGR_CTRL_G1NSEN];
        if (!has_el3 && secdis)
        begin
            eff_ns     = 1'b1;
            eff_froute = 1'b0;
            eff_iroute = 1'b0;
        end
        else if (!has_el3 && pe_secure)
        begin
            eff_ns     = 1'b0;
            eff_froute = 1'b0;
            eff_iroute = 1'b0;
            eff_g1nsen = 1'b0;
        end
        else if (!has_el3)
        begin
            eff_ns     = 1'b1;
            eff_froute = 1'b1;
            eff_iroute = 1'b0;
            eff_g0en   = 1'b0;
            eff_g1sen  = 1'b0;
        end
        cur_secure = (sec_sync[1] || el_s2 == IGR_EL3) && !eff_ns;
        if (el_s2 == IGR_EL3)
            cur_secure = 1'b1;
        g1s_as_g0  = !secdis && (!has_el3 || !cfg[`IGR_CFG_SRE_S]);
    end

    // ----------------------------------------
    // Signalling decision
    // ----------------------------------------
    function automatic logic [1:0] lines_for
    (
        input logic [1:0] grp,
        input logic       sd,
        input logic       el3,
        input logic       w32,
        input logic [1:0] el,
        input logic       sec,
        input logic       as_g0
    );
        logic g1_fiq;
        g1_fiq = 1'b0;
        if (grp == IGR_GRP0 || (grp == IGR_GRP1_SEC && as_g0))
            return 2'b10;
        if (sd && !el3)
            return 2'b01;
        if (el == IGR_EL3)
            g1_fiq = !w32;
        else
            g1_fiq = sd ? 1'b0 : (sec != (grp == IGR_GRP1_SEC));
        return g1_fiq ? 2'b10 : 2'b01;
    endfunction

    logic       pend_valid;
    logic [7:0] pend_pri;
    logic [1:0] pend_grp;
    logic       grp_enabled;
    logic       sufficient;
    logic [1:0] lines;

    always_comb
    begin
        pend_valid = pend[`IGR_PEND_VALID];
        pend_pri   = pend[`IGR_PEND_PRI_LSB +: 8];
        pend_grp   = pend[`IGR_PEND_GRP_LSB +: 2];
        if (secdis && pend_grp == IGR_GRP1_NS)
            pend_grp = IGR_GRP1_SEC;
        case (pend_grp)
            IGR_GRP0:     grp_enabled = eff_g0en;
            IGR_GRP1_SEC: grp_enabled = secdis ? eff_g1nsen : eff_g1sen;
            IGR_GRP1_NS:  grp_enabled = eff_g1nsen;
            default:      grp_enabled = 1'b0;
        endcase
        sufficient = pend_valid && grp_enabled
                  && pend_pri < prio[`IGR_PRIO_PMR_LSB +: 8]
                  && pend_pri < prio[`IGR_PRIO_RPR_LSB +: 8];
        lines = lines_for(pend_grp, secdis, has_el3, el3_w32, el_s2, cur_secure, g1s_as_g0);
        // Outputs follow the two-stage synchronised level and state every cycle, and with no EL3 also the unsynchronised pe_secure
        next_fiq = sufficient && lines[1];
        next_irq = sufficient && lines[0];
    end

    // ----------------------------------------
    // Binary point selection
    // ----------------------------------------
    logic [2:0] bp_g0;
    logic [2:0] bp_g1;

    always_comb
    begin
        bp_g0 = bpr[`IGR_BPR_G0_LSB +: 3];
        if (cur_secure)
            bp_g1 = ctrl[`IGR_CTRL_CBPRS] ? bp_g0 : bpr[`IGR_BPR_G1S_LSB +: 3];
        else
            bp_g1 = ctrl[`IGR_CTRL_CBPRNS] ? bp_g0 : bpr[`IGR_BPR_G1NS_LSB +: 3];
        if (ctrl[`IGR_CTRL_CBPR])
            bp_g1 = bp_g0;
    end

    // ----------------------------------------
    // Access check on write to REQ
    // ----------------------------------------
    logic [3:0] rq_kind;
    logic       rq_sec;
    logic [1:0] rq_el;
    logic       virt;
    igr_acc_t   verdict;

    always_comb
    begin
        rq_kind = pwdata[`IGR_REQ_KIND_LSB +: 4];
        rq_sec  = pwdata[`IGR_REQ_SEC];
        rq_el   = pwdata[`IGR_REQ_EL_LSB +: 2];
        virt    = rq_el == IGR_EL1 && eff_ns
               && (ctrl[`IGR_CTRL_FMO] || ctrl[`IGR_CTRL_IMO]);
        verdict = IGR_ACC_OK;
        case (rq_kind)
            IGR_REQ_SWINT0, IGR_REQ_SWINT_ALT:
            begin
                if (virt)
                    verdict = IGR_ACC_TRAP_EL2;
                else if (!secdis && !rq_sec && !ctrl[`IGR_CTRL_NSACR])
                    verdict = IGR_ACC_DENY;
            end
            IGR_REQ_SWINT1:
                verdict = virt ? IGR_ACC_TRAP_EL2 : IGR_ACC_OK;
            IGR_REQ_CONFIG, IGR_REQ_ACK, IGR_REQ_DROP, IGR_REQ_DEACT:
                verdict = (!secdis && !rq_sec && pend_grp != IGR_GRP1_NS)
                        ? IGR_ACC_DENY : IGR_ACC_OK;
            IGR_REQ_REG_G0:
                verdict = virt && ctrl[`IGR_CTRL_FMO] ? IGR_ACC_VIRTUAL : IGR_ACC_OK;
            IGR_REQ_REG_G1:
                verdict = virt && ctrl[`IGR_CTRL_IMO] ? IGR_ACC_VIRTUAL : IGR_ACC_OK;
            IGR_REQ_REG_COMMON:
                verdict = virt ? IGR_ACC_VIRTUAL : IGR_ACC_OK;
            default:
                verdict = IGR_ACC_DENY;
        endcase
    end

    // ----------------------------------------
    // Register next state and read mux
    // ----------------------------------------
    always_comb
    begin
        next_cfg        = cfg;
        next_ctrl       = ctrl;
        next_bpr        = bpr;
        next_prio       = prio;
        next_pend       = pend;
        next_req_result = req_result;
        next_prdata     = prdata;
        if (wr_en)
        begin
            case (paddr)
                `IGR_OFF_CFG:  next_cfg  = pwdata[4:0];
                `IGR_OFF_CTRL: next_ctrl = pwdata[13:0];
                `IGR_OFF_BPR:  next_bpr  = pwdata[11:0];
                `IGR_OFF_PRIO: next_prio = pwdata[15:0];
                `IGR_OFF_PEND: next_pend = pwdata[10:0];
                `IGR_OFF_REQ:  next_req_result = {24'h00_0000, 1'b1, pwdata[6:0]} | {22'h00_0000, verdict, 8'h00};
                default:       next_cfg  = cfg;
            endcase
        end
        if (psel && !penable && !pwrite)
        begin
            case (paddr)
                `IGR_OFF_CFG:    next_prdata = {27'h000_0000, cfg};
                `IGR_OFF_CTRL:   next_prdata = {18'h0_0000, ctrl};
                `IGR_OFF_BPR:    next_prdata = {20'h0_0000, bpr};
                `IGR_OFF_PRIO:   next_prdata = {16'h0000, prio};
                `IGR_OFF_PEND:   next_prdata = {21'h00_0000, pend};
                `IGR_OFF_STATUS: next_prdata = {22'h00_0000, bp_g1, bp_g0, g1s_as_g0, cur_secure, irq_q, fiq_q};
                `IGR_OFF_REQ:    next_prdata = req_result;
                default:         next_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg         <= 5'(`IGR_RST_CFG);
            ctrl        <= 14'(`IGR_RST_CTRL);
            bpr         <= 12'(`IGR_RST_BPR);
            prio        <= 16'(`IGR_RST_PRIO);
            pend        <= 11'(`IGR_RST_PEND);
            req_result  <= 32'h0000_0000;
            prdata      <= 32'h0000_0000;
            fiq_q       <= 1'b0;
            irq_q       <= 1'b0;
            el_s1       <= 2'b00;
            el_s2       <= 2'b00;
            sec_sync[0] <= 1'b0;
            sec_sync[1] <= 1'b0;
        end
        else
        begin
            cfg         <= next_cfg;
            ctrl        <= next_ctrl;
            bpr         <= next_bpr;
            prio        <= next_prio;
            pend        <= next_pend;
            req_result  <= next_req_result;
            prdata      <= next_prdata;
            fiq_q       <= next_fiq;
            irq_q       <= next_irq;
            el_s1       <= pe_el;
            el_s2       <= el_s1;
            sec_sync[0] <= pe_secure;
            sec_sync[1] <= sec_sync[0];
        end
    end

    assign fiq = fiq_q;
    assign irq = irq_q;

endmodule

// ---- shared/igr_params.svh ----
`ifndef IGR_PARAMS_SVH
`define IGR_PARAMS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define IGR_OFF_CFG      12'h000
`define IGR_OFF_CTRL     12'h004
`define IGR_OFF_BPR      12'h008
`define IGR_OFF_PRIO     12'h00C
`define IGR_OFF_PEND     12'h010
`define IGR_OFF_STATUS   12'h014
`define IGR_OFF_REQ      12'h018

// ----------------------------------------
// Field positions
// ----------------------------------------
// CFG
`define IGR_CFG_SECDIS   0
`define IGR_CFG_HAS_EL3  1
`define IGR_CFG_HAS_EL2  2
`define IGR_CFG_EL3_W32  3
`define IGR_CFG_SRE_S    4
// CTRL
`define IGR_CTRL_G0EN    0
`define IGR_CTRL_G1SEN   1
`define IGR_CTRL_G1NSEN  2
`define IGR_CTRL_CBPR    3
`define IGR_CTRL_CBPRNS  4
`define IGR_CTRL_CBPRS   5
`define IGR_CTRL_FROUTE  6
`define IGR_CTRL_IROUTE  7
`define IGR_CTRL_NS      8
`define IGR_CTRL_FMO     9
`define IGR_CTRL_IMO     10
`define IGR_CTRL_SREEN   11
`define IGR_CTRL_DFB     12
`define IGR_CTRL_NSACR   13
// BPR
`define IGR_BPR_G0_LSB   0
`define IGR_BPR_G1S_LSB  4
`define IGR_BPR_G1NS_LSB 8
// PRIO
`define IGR_PRIO_PMR_LSB 0
`define IGR_PRIO_RPR_LSB 8
// PEND
`define IGR_PEND_PRI_LSB 0
`define IGR_PEND_GRP_LSB 8
`define IGR_PEND_VALID   10
// REQ (software interrupt request / access check)
`define IGR_REQ_KIND_LSB 0
`define IGR_REQ_SEC      4
`define IGR_REQ_EL_LSB   5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define IGR_RST_CFG      32'h0000_0000
`define IGR_RST_CTRL     32'h0000_0000
`define IGR_RST_BPR      32'h0000_0000
`define IGR_RST_PRIO     32'h0000_FFFF
`define IGR_RST_PEND     32'h0000_0000

`endif

// ---- shared/igr_pkg.sv ----
package igr_pkg;

    typedef enum logic [1:0]
    {
        IGR_GRP0,
        IGR_GRP1_SEC,
        IGR_GRP1_NS
    } igr_group_t;

    typedef enum logic [1:0]
    {
        IGR_EL0,
        IGR_EL1,
        IGR_EL2,
        IGR_EL3
    } igr_el_t;

    typedef enum logic [3:0]
    {
        IGR_REQ_SWINT0,
        IGR_REQ_SWINT1,
        IGR_REQ_SWINT_ALT,
        IGR_REQ_CONFIG,
        IGR_REQ_ACK,
        IGR_REQ_DROP,
        IGR_REQ_DEACT,
        IGR_REQ_REG_G0,
        IGR_REQ_REG_G1,
        IGR_REQ_REG_COMMON
    } igr_req_kind_t;

    typedef enum logic [1:0]
    {
        IGR_ACC_OK,
        IGR_ACC_DENY,
        IGR_ACC_VIRTUAL,
        IGR_ACC_TRAP_EL2
    } igr_acc_t;

endpackage

// ---- test/igr_routing_monitor.sv ----
module igr_monitor
(
    // APB
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [11:0]      paddr,
    input wire logic [31:0]      pwdata,
    input wire logic [31:0]      prdata,
    input wire logic             pready,
    input wire logic             pslverr,
    // Core state and lines
    input wire igr_pkg::igr_el_t pe_el,
    input wire logic             pe_secure,
    input wire logic             pe_ctx_sync,
    input wire logic             fiq,
    input wire logic             irq
);
    timeunit 1ns;
    timeprecision 1ns;
    import igr_pkg::*;

    igr_el_t    last_el;
    logic       last_sec;
    logic [2:0] quiet;
    logic [2:0] next_quiet;

    // Cycles since a write or a core state change
    always_comb
    begin
        next_quiet = (quiet == 3'h7) ? quiet : quiet + 3'h1;
        if ((psel && penable && pwrite) || pe_el != last_el || pe_secure != last_sec)
            next_quiet = 3'h0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            last_el  <= IGR_EL0;
            last_sec <= 1'b0;
            quiet    <= 3'h0;
        end
        else
        begin
            last_el  <= pe_el;
            last_sec <= pe_secure;
            quiet    <= next_quiet;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ready_high_a: assert property (pready)
        else $error("pready low");
    err_phase_a: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access phase");
    err_unmap_a: assert property (psel && penable && paddr[11:2] > 10'h006 |-> pslverr)
        else $error("unmapped access not refused");
    err_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("refused read not zero");
    rdata_hold_a: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
        else $error("prdata changed outside read setup");
    line_excl_a: assert property (!(fiq && irq))
        else $error("fiq and irq both high");
    fiq_cause_a: assert property ($changed(fiq) |-> quiet < 3'h6)
        else $error("fiq changed without cause");
    irq_cause_a: assert property ($changed(irq) |-> quiet < 3'h6)
        else $error("irq changed without cause");
endmodule

bind igr_routing igr_monitor u_mon
(
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pe_el, .pe_secure, .pe_ctx_sync, .fiq, .irq
);

// ---- test/igr_pe_model.sv ----
module igr_pe_model
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Requested state
    input  wire logic [1:0]  want_el,
    input  wire logic        want_sec,
    input  wire logic        slow,
    // Core state
    output igr_pkg::igr_el_t pe_el,
    output logic             pe_secure,
    output logic             pe_ctx_sync
);
    timeunit 1ns;
    timeprecision 1ns;
    import igr_pkg::*;

    // Exception entry or return, marked by a sync pulse
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pe_el       <= IGR_EL0;
            pe_secure   <= 1'b0;
            pe_ctx_sync <= 1'b0;
        end
        else
        begin
            pe_ctx_sync <= 1'b0;
            if (want_el != pe_el || want_sec != pe_secure)
            begin
                if (slow)
                    repeat (3) @(posedge pclk);
                pe_el       <= igr_el_t'(want_el);
                pe_secure   <= want_sec;
                pe_ctx_sync <= 1'b1;
            end
        end
    end
endmodule

// ---- test/igr_routing_test.sv ----
module igr_routing_test;
    timeunit 1ns;
    timeprecision 1ns;

    logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, fiq, irq;
    logic             pe_secure, pe_ctx_sync, want_sec, slow;
    logic [1:0]       want_el;
    logic [11:0]      paddr;
    logic [31:0]      pwdata, prdata;
    logic [63:0]      note, exp_q[$];
    igr_pkg::igr_el_t pe_el;
    int               n_errors, n_checks, m, g, el, s;
    logic [31:0]      cfg_tab [5] = '{32'h0000_0012, 32'h0000_001A, 32'h0000_0001, 32'h0000_0000,
                                      32'h0000_0004};
    logic [39:0]      pri_tab [5] = '{40'h10_2020_0701, 40'h20_3020_0700, 40'h20_2030_0700,
                                      40'h1F_2020_0701, 40'h10_FFFF_0600};
    logic [39:0]      req_tab [10] = '{40'h12_0000_2001, 40'h12_2000_2000, 40'h12_0000_3000,
                                       40'h13_0000_2000, 40'h12_0000_2201, 40'h12_2300_2702,
                                       40'h12_2500_2103, 40'h12_2300_4700, 40'h12_0000_2401,
                                       40'h13_0000_2400};

    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    igr_routing u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
                       .pready, .pslverr, .pe_el, .pe_secure, .pe_ctx_sync, .fiq, .irq);
    igr_pe_model u_pe (.pclk, .presetn, .want_el, .want_sec, .slow, .pe_el, .pe_secure, .pe_ctx_sync);

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] msk);
        exp_q.push_back({msk, e});
        xfer(1'b0, a, 32'h0000_0000);
    endtask

    task automatic go(input int e, input int sec);
        want_el <= e[1:0];
        want_sec <= sec[0];
        slow <= 1'($urandom % 2);
        repeat (12) @(posedge pclk);
    endtask

    // Expected {irq, fiq} for mode, group, level and state
    function automatic logic [1:0] lines(input int md, input int gr, input int lv, input int sc);
        if (gr == 0 || md == 3)
            return 2'b01;
        if (md == 2)
            return 2'b10;
        if (lv == 3)
            return md == 1 ? 2'b10 : 2'b01;
        return ((gr == 1) != (sc == 1)) ? 2'b01 : 2'b10;
    endfunction

    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1)
            chk("pslverr", 32'(pslverr), 32'(paddr > 12'h018 || paddr[1:0] != 2'b00));
        if (psel && penable && !pwrite && pready === 1'b1)
        begin
            note = exp_q.pop_front();
            chk("prdata", prdata & note[63:32], note[31:0] & note[63:32]);
            if (paddr == 12'h014)
                chk("fiq irq", {30'h0, irq & note[33], fiq & note[32]}, {30'h0, note[1:0] & note[33:32]});
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        test_done();
    end

    initial
    begin
        {presetn, psel, penable, pwrite, want_sec, slow} = '0;
        {paddr, pwdata, want_el} = '0;
        void'($urandom(48156));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++)
            rd(i == 5 ? 12'h01C : 12'(i * 4), i == 3 ? 32'h0000_FFFF : 32'h0000_0000, '1);
        // ----------------------------
        // Line choice per mode
        // ----------------------------
        for (int i = 0; i < 30; i++)
        begin
            m = $urandom % 5;
            el = $urandom % 4;
            s = $urandom % 2;
            g = $urandom % 3;
            if (m < 2 && el > 1) s = el - 2;
            if (m == 1 && s == 1 && el < 3) el = 0;
            if (m >= 2) el = el % (5 - m);
            if (m >= 3) s = (m == 3);
            if (m >= 3) g = (m == 3) ? g % 2 : 2;
            xfer(1'b1, 12'h000, cfg_tab[m]);
            xfer(1'b1, 12'h004, s == 1 ? 32'h0000_0007 : 32'h0000_0107);
            xfer(1'b1, 12'h010, 32'h0000_0410 | 32'(g) << 8);
            go(el, s);
            rd(12'h014, {28'h0, m >= 3, s == 1, lines(m, g, el, s)}, m == 2 ? 32'h3 : 32'hF);
        end
        xfer(1'b1, 12'h000, 32'h0000_0012);
        go(1, 0);
        foreach (pri_tab[i])
        begin
            xfer(1'b1, 12'h004, {24'h0, pri_tab[i][15:8]} | 32'h0000_0100);
            xfer(1'b1, 12'h00C, {16'h0, pri_tab[i][31:16]});
            xfer(1'b1, 12'h010, {24'h0, pri_tab[i][39:32]} | 32'h0000_0400);
            rd(12'h014, {24'h0, pri_tab[i][7:0]}, 32'h0000_0003);
        end
        xfer(1'b1, 12'h008, 32'h0000_0653);
        for (int i = 0; i < 8; i++)
        begin
            s = i % 2;
            xfer(1'b1, 12'h004, (i / 2 == 3 ? 32'h8 : 32'(i / 2) << 4) | (s == 1 ? 32'h0 : 32'h100));
            go(1, s);
            rd(12'h014, 32'h30 | 32'(s == 1 ? (i / 2 >= 2 ? 3 : 5) : (i / 2 % 2 == 1 ? 3 : 6)) << 7, 32'h3F0);
        end
        foreach (req_tab[i])
        begin
            xfer(1'b1, 12'h000, {24'h0, req_tab[i][39:32]});
            xfer(1'b1, 12'h004, {16'h0, req_tab[i][31:16]});
            xfer(1'b1, 12'h018, {24'h0, req_tab[i][15:8]});
            rd(12'h018, {22'h0, req_tab[i][1:0], 1'b1, req_tab[i][14:8]}, 32'h3FF);
        end
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h00C, 32'h0000_FFFF, '1);
        rd(12'h004, 32'h0000_0000, '1);
        repeat (2) @(posedge pclk);
        chk("notes left", 32'(exp_q.size()), 32'h0000_0000);
        test_done();
    end
endmodule
